//--- rtl/bus_cmd_pkg.sv
// Notes on behaviour
// [RQ1] Decode three status bits into cycle kinds
// [RQ2] System mode, gate low: drive command strobes
// [RQ3] System mode, gate high: strobes high-impedance
// [RQ4] I/O mode ignores the address gate
// [RQ5] Command gate low holds strobes, enables inactive
// [RQ6] Bus mode high selects I/O mode
// [RQ7] Active-low three-state memory read strobe
// [RQ8] Active-low three-state memory write strobe
// [RQ9] Early memory write one clock before normal
// [RQ10] Active-low three-state I/O read strobe
// [RQ11] Active-low three-state I/O write strobe
// [RQ12] Early I/O write one clock before normal
// [RQ13] Active-low interrupt acknowledge; peripheral returns vector
// [RQ14] Address latch strobe; latch on falling edge
// [RQ15] Data transceiver enable during transfers
// [RQ16] Direction high outbound, low inbound
// [RQ17] Shared output: cascade or peripheral enable
// [RQ18] Slaves read cascade address on rising enable
// [RQ19] I/O mode peripheral enable active low
// [RQ20] Latch strobe pulses once per cycle start
// [RQ21] Idle code ends strobes and data enable
package bus_cmd_pkg;

   // ----------------------------------------
   // Status codes
   // ----------------------------------------
   localparam logic [2:0] ST_IRQ_ACK = 3'h0;
   localparam logic [2:0] ST_IO_READ = 3'h1;
   localparam logic [2:0] ST_IO_WRITE = 3'h2;
   localparam logic [2:0] ST_HALT = 3'h3;
   localparam logic [2:0] ST_FETCH = 3'h4;
   localparam logic [2:0] ST_MEM_READ = 3'h5;
   localparam logic [2:0] ST_MEM_WRITE = 3'h6;
   localparam logic [2:0] ST_IDLE = 3'h7;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic STROBE_N_RST = 1'b1;
   localparam logic ENABLE_RST = 1'b0;
   localparam logic DIR_RST = 1'b0;

   // Kind of bus cycle in progress
   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_IRQ_ACK = 3'b001,
      K_IO_RD = 3'b010,
      K_IO_WR = 3'b011,
      K_MEM_RD = 3'b100,
      K_MEM_WR = 3'b101
   } cycle_kind_t;

   // Clock phase within a bus cycle
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_T1 = 2'b01,
      PH_T2 = 2'b10,
      PH_T3 = 2'b11
   } phase_t;

endpackage

//--- rtl/bus_cmd_if.sv
`timescale 1ns/100ps
// Decode and mode information shared inside the controller
interface bus_cmd_if;
   import bus_cmd_pkg::*;
   logic [2:0] status_code;
   bus_cmd_pkg::cycle_kind_t kind;
   logic io_mode;
   logic address_gate_n;
   logic command_gate;
   logic cmd_drive;
   logic cmd_allow;

   modport dec (input status_code, output kind);
   modport mode (input io_mode, address_gate_n, command_gate, output cmd_drive, cmd_allow);
   modport ctl (output status_code, io_mode, address_gate_n, command_gate,
                input kind, cmd_drive, cmd_allow);
endinterface // bus_cmd_if

//--- rtl/status_decoder.sv
`timescale 1ns/100ps
// Maps the status code onto a cycle kind
module status_decoder (
   bus_cmd_if.dec bus
);
   import bus_cmd_pkg::*;

   // ----------------------------------------
   // Code decode
   // ----------------------------------------
   always_comb begin
      unique case (bus.status_code)
         ST_IRQ_ACK: bus.kind = K_IRQ_ACK; // see [RQ1]
         ST_IO_READ: bus.kind = K_IO_RD;
         ST_IO_WRITE: bus.kind = K_IO_WR;
         ST_FETCH,
         ST_MEM_READ: bus.kind = K_MEM_RD;
         ST_MEM_WRITE: bus.kind = K_MEM_WR;
         ST_HALT,
         ST_IDLE: bus.kind = K_NONE;
      endcase
   end
endmodule // status_decoder

//--- rtl/mode_control.sv
`timescale 1ns/100ps
// Works out strobe drive and gating from the mode pins
module mode_control (
   bus_cmd_if.mode bus
);
   import bus_cmd_pkg::*;

   // ----------------------------------------
   // Drive and gate
   // ----------------------------------------
   // I/O mode drives always; system mode follows the address gate
   assign bus.cmd_drive = bus.io_mode | ~bus.address_gate_n; // see [RQ2] see [RQ3] see [RQ4]
   assign bus.cmd_allow = bus.command_gate; // see [RQ5]
endmodule // mode_control

//--- rtl/bus_cmd_ctrl.sv
`timescale 1ns/100ps
// Status-driven bus command controller
module bus_cmd_ctrl (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic [2:0] I_CPU_STATUS_CODE,
   input wire logic I_ADDRESS_GATE_N,
   input wire logic I_COMMAND_GATE,
   input wire logic I_IO_BUS_MODE_SEL,
   output logic O_MEM_READ_STROBE_N,
   output logic O_MEM_WRITE_STROBE_N,
   output logic O_EARLY_MEM_WRITE_STROBE_N,
   output logic O_IO_READ_STROBE_N,
   output logic O_IO_WRITE_STROBE_N,
   output logic O_EARLY_IO_WRITE_STROBE_N,
   output logic O_IRQ_ACK_STROBE_N,
   output logic O_COMMAND_OE,
   output logic O_ADDR_LATCH_STROBE,
   output logic O_DATA_XCVR_ENABLE,
   output logic O_XCVR_DIRECTION,
   output logic O_CASCADE_OR_PERIPH_ENABLE
);
   import bus_cmd_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      bus_cmd_pkg::phase_t phase;
      bus_cmd_pkg::cycle_kind_t kind;
      logic mem_rd_n;
      logic mem_wr_n;
      logic early_mem_wr_n;
      logic io_rd_n;
      logic io_wr_n;
      logic early_io_wr_n;
      logic irq_ack_n;
      logic cmd_oe;
      logic latch_stb;
      logic xcvr_en;
      logic xcvr_dir;
      logic shared_en;
   } state_t;

   state_t state_q;
   state_t state_d;
   logic io_mode;
   logic in_cycle;
   logic strobe_phase;
   logic late_phase;
   logic xfer_on;

   bus_cmd_if bus ();

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Pins into the shared bundle
   assign bus.status_code = I_CPU_STATUS_CODE;
   assign bus.address_gate_n = I_ADDRESS_GATE_N;
   assign bus.command_gate = I_COMMAND_GATE;
   assign bus.io_mode = io_mode;
   assign io_mode = I_IO_BUS_MODE_SEL; // see [RQ6]

   status_decoder u_decoder (
      .bus(bus)
   );

   mode_control u_mode (
      .bus(bus)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q.phase)
         PH_IDLE: begin
            // A new cycle starts when the code leaves idle or halt
            if (bus.kind != K_NONE) begin
               state_d.phase = PH_T1; // see [RQ20]
               state_d.kind = bus.kind;
            end
         end
         PH_T1: begin
            state_d.phase = PH_T2;
         end
         PH_T2: begin
            state_d.phase = PH_T3;
         end
         PH_T3: begin
            state_d.phase = PH_T3;
         end
      endcase
      // Return to the idle code closes the cycle
      if (state_q.phase != PH_IDLE && I_CPU_STATUS_CODE == ST_IDLE) begin
         state_d.phase = PH_IDLE; // see [RQ21]
         state_d.kind = K_NONE;
      end

      // Phase qualifiers from the settled next phase, no loop through assigns
      in_cycle = state_d.phase != PH_IDLE;
      strobe_phase = (state_d.phase == PH_T2) || (state_d.phase == PH_T3);
      late_phase = state_d.phase == PH_T3;
      xfer_on = strobe_phase && bus.cmd_allow && (state_d.kind != K_NONE);

      // Command strobes, each gated by the command gate
      state_d.mem_rd_n = ~(xfer_on && state_d.kind == K_MEM_RD); // see [RQ7]
      state_d.mem_wr_n = ~(xfer_on && late_phase && state_d.kind == K_MEM_WR); // see [RQ8]
      state_d.early_mem_wr_n = ~(xfer_on && state_d.kind == K_MEM_WR); // see [RQ9]
      state_d.io_rd_n = ~(xfer_on && state_d.kind == K_IO_RD); // see [RQ10]
      state_d.io_wr_n = ~(xfer_on && late_phase && state_d.kind == K_IO_WR); // see [RQ11]
      state_d.early_io_wr_n = ~(xfer_on && state_d.kind == K_IO_WR); // see [RQ12]
      state_d.irq_ack_n = ~(xfer_on && state_d.kind == K_IRQ_ACK); // see [RQ13]
      state_d.cmd_oe = bus.cmd_drive; // see [RQ2] see [RQ3] see [RQ4]

      // Single latch pulse in the first phase
      state_d.latch_stb = state_d.phase == PH_T1; // see [RQ14] see [RQ20]

      // Transceiver control
      state_d.xcvr_en = xfer_on; // see [RQ15] see [RQ5]
      state_d.xcvr_dir = in_cycle &&
                         (state_d.kind == K_MEM_WR || state_d.kind == K_IO_WR); // see [RQ16]

      // Shared pin: cascade high in acknowledge, or peripheral enable low
      if (io_mode) begin
         state_d.shared_en = ~xfer_on; // see [RQ17] see [RQ19]
      end else begin
         state_d.shared_en = in_cycle && state_d.kind == K_IRQ_ACK; // see [RQ17]
      end

      if (I_RESET) begin
         state_d.phase = PH_IDLE;
         state_d.kind = K_NONE;
         state_d.mem_rd_n = STROBE_N_RST;
         state_d.mem_wr_n = STROBE_N_RST;
         state_d.early_mem_wr_n = STROBE_N_RST;
         state_d.io_rd_n = STROBE_N_RST;
         state_d.io_wr_n = STROBE_N_RST;
         state_d.early_io_wr_n = STROBE_N_RST;
         state_d.irq_ack_n = STROBE_N_RST;
         state_d.cmd_oe = ENABLE_RST;
         state_d.latch_stb = ENABLE_RST;
         state_d.xcvr_en = ENABLE_RST;
         state_d.xcvr_dir = DIR_RST;
         state_d.shared_en = ENABLE_RST;
      end
   end

   // State register
   always_ff @(posedge I_CLK_SYS) begin
      state_q <= state_d;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign O_MEM_READ_STROBE_N = state_q.mem_rd_n;
   assign O_MEM_WRITE_STROBE_N = state_q.mem_wr_n;
   assign O_EARLY_MEM_WRITE_STROBE_N = state_q.early_mem_wr_n;
   assign O_IO_READ_STROBE_N = state_q.io_rd_n;
   assign O_IO_WRITE_STROBE_N = state_q.io_wr_n;
   assign O_EARLY_IO_WRITE_STROBE_N = state_q.early_io_wr_n;
   assign O_IRQ_ACK_STROBE_N = state_q.irq_ack_n;
   assign O_COMMAND_OE = state_q.cmd_oe;
   assign O_ADDR_LATCH_STROBE = state_q.latch_stb;
   assign O_DATA_XCVR_ENABLE = state_q.xcvr_en;
   assign O_XCVR_DIRECTION = state_q.xcvr_dir;
   assign O_CASCADE_OR_PERIPH_ENABLE = state_q.shared_en;
endmodule // bus_cmd_ctrl

//--- dv/bus_cmd_ctrl_monitor.sv
`timescale 1ns/100ps
// Watches the controller ports for strobe timing and gating
module bus_cmd_ctrl_monitor (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic [2:0] I_CPU_STATUS_CODE,
   input wire logic I_ADDRESS_GATE_N,
   input wire logic I_COMMAND_GATE,
   input wire logic I_IO_BUS_MODE_SEL,
   input wire logic O_MEM_READ_STROBE_N,
   input wire logic O_MEM_WRITE_STROBE_N,
   input wire logic O_EARLY_MEM_WRITE_STROBE_N,
   input wire logic O_IO_READ_STROBE_N,
   input wire logic O_IO_WRITE_STROBE_N,
   input wire logic O_EARLY_IO_WRITE_STROBE_N,
   input wire logic O_IRQ_ACK_STROBE_N,
   input wire logic O_COMMAND_OE,
   input wire logic O_ADDR_LATCH_STROBE,
   input wire logic O_DATA_XCVR_ENABLE,
   input wire logic O_XCVR_DIRECTION,
   input wire logic O_CASCADE_OR_PERIPH_ENABLE
);
   // All seven command strobes inactive
   wire logic quiet = &{O_MEM_READ_STROBE_N, O_MEM_WRITE_STROBE_N, O_EARLY_MEM_WRITE_STROBE_N,
      O_IO_READ_STROBE_N, O_IO_WRITE_STROBE_N, O_EARLY_IO_WRITE_STROBE_N, O_IRQ_ACK_STROBE_N};
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);
   // Latch strobe and bus cycle start
   lat_one_a: assert property (O_ADDR_LATCH_STROBE |=> !O_ADDR_LATCH_STROBE)
      else $error("latch strobe too long");
   lat_start_a: assert property ($rose(O_ADDR_LATCH_STROBE) |->
      !($past(I_CPU_STATUS_CODE) inside {3'h3, 3'h7})) else $error("latch without cycle");
   // Output drive and gating; reset edge excluded since OE is still cleared then
   oe_mode_a: assert property (!I_RESET |=>
      O_COMMAND_OE == ($past(I_IO_BUS_MODE_SEL) | ~$past(I_ADDRESS_GATE_N)))
      else $error("drive wrong");
   gate_off_a: assert property (!I_COMMAND_GATE |=> quiet && !O_DATA_XCVR_ENABLE)
      else $error("gate ignored");
   // Early write leads the normal one while the command gate stays open
   early_mwr_a: assert property ($fell(O_EARLY_MEM_WRITE_STROBE_N) &&
      I_CPU_STATUS_CODE != 3'h7 && I_COMMAND_GATE |=> !O_MEM_WRITE_STROBE_N)
      else $error("write late");
   // Cycle end and direction
   idle_end_a: assert property (I_CPU_STATUS_CODE == 3'h7 |=>
      quiet && !O_DATA_XCVR_ENABLE && !O_XCVR_DIRECTION) else $error("idle kept cycle");
   dir_write_a: assert property (!(O_MEM_WRITE_STROBE_N && O_IO_WRITE_STROBE_N) |->
      O_XCVR_DIRECTION) else $error("direction low on write");
   periph_en_a: assert property (I_IO_BUS_MODE_SEL && $past(I_IO_BUS_MODE_SEL) &&
      !$past(I_RESET) |-> O_CASCADE_OR_PERIPH_ENABLE != O_DATA_XCVR_ENABLE) else $error("periph");
   cover property ($fell(O_MEM_WRITE_STROBE_N));
   cover property ($fell(O_IRQ_ACK_STROBE_N));
   cover property ($fell(O_IO_READ_STROBE_N));
endmodule // bus_cmd_ctrl_monitor

bind bus_cmd_ctrl bus_cmd_ctrl_monitor u_mon (
   .I_CLK_SYS(I_CLK_SYS),
   .I_RESET(I_RESET),
   .I_CPU_STATUS_CODE(I_CPU_STATUS_CODE),
   .I_ADDRESS_GATE_N(I_ADDRESS_GATE_N),
   .I_COMMAND_GATE(I_COMMAND_GATE),
   .I_IO_BUS_MODE_SEL(I_IO_BUS_MODE_SEL),
   .O_MEM_READ_STROBE_N(O_MEM_READ_STROBE_N),
   .O_MEM_WRITE_STROBE_N(O_MEM_WRITE_STROBE_N),
   .O_EARLY_MEM_WRITE_STROBE_N(O_EARLY_MEM_WRITE_STROBE_N),
   .O_IO_READ_STROBE_N(O_IO_READ_STROBE_N),
   .O_IO_WRITE_STROBE_N(O_IO_WRITE_STROBE_N),
   .O_EARLY_IO_WRITE_STROBE_N(O_EARLY_IO_WRITE_STROBE_N),
   .O_IRQ_ACK_STROBE_N(O_IRQ_ACK_STROBE_N),
   .O_COMMAND_OE(O_COMMAND_OE),
   .O_ADDR_LATCH_STROBE(O_ADDR_LATCH_STROBE),
   .O_DATA_XCVR_ENABLE(O_DATA_XCVR_ENABLE),
   .O_XCVR_DIRECTION(O_XCVR_DIRECTION),
   .O_CASCADE_OR_PERIPH_ENABLE(O_CASCADE_OR_PERIPH_ENABLE)
);

//--- dv/cpu_status_model.sv
`timescale 1ns/100ps
// Processor side: one status code per bus cycle, idle between
module cpu_status_model (
   input wire logic i_clk,
   output logic [2:0] o_status
);
   initial o_status = 3'h7;
   // Code held for n sampling edges, then idle
   task automatic run(input logic [2:0] code, input int n);
      @(posedge i_clk) o_status <= code;
      repeat (n) @(posedge i_clk);
      o_status <= 3'h7;
   endtask
endmodule // cpu_status_model

//--- dv/bus_cmd_ctrl_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the bus command controller
module bus_cmd_ctrl_tb_top;
   localparam logic [6:0] LOWS [8] = '{7'h7e, 7'h77, 7'h79, 7'h7f, 7'h3f, 7'h3f, 7'h4f, 7'h7f};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic agn = 1'b0;
   logic gate = 1'b1;
   logic iom = 1'b0;
   logic [2:0] code;
   wire [6:0] stb;
   logic oe, addr_latch_strobe, xen, dir, shr;
   int fails = 0;
   int n_compared = 0;
   int pulses = 0;
   int ticks = 0;
   int casc_reads = 0;
   logic shr_seen = 1'b0;
   cpu_status_model u_cpu (.i_clk(clk), .o_status(code));
   bus_cmd_ctrl u_dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_CPU_STATUS_CODE(code),
      .I_ADDRESS_GATE_N(agn), .I_COMMAND_GATE(gate), .I_IO_BUS_MODE_SEL(iom),
      .O_MEM_READ_STROBE_N(stb[6]), .O_MEM_WRITE_STROBE_N(stb[5]),
      .O_EARLY_MEM_WRITE_STROBE_N(stb[4]), .O_IO_READ_STROBE_N(stb[3]),
      .O_IO_WRITE_STROBE_N(stb[2]), .O_EARLY_IO_WRITE_STROBE_N(stb[1]),
      .O_IRQ_ACK_STROBE_N(stb[0]), .O_COMMAND_OE(oe), .O_ADDR_LATCH_STROBE(addr_latch_strobe),
      .O_DATA_XCVR_ENABLE(xen), .O_XCVR_DIRECTION(dir), .O_CASCADE_OR_PERIPH_ENABLE(shr));
   // Clock
   initial forever #5 clk = ~clk;
   // Latch pulse count and hang limit
   always @(posedge clk) begin
      ticks++;
      pulses += int'(addr_latch_strobe);
      // Slave controllers read the cascade address on each rise
      if (!iom && shr && !shr_seen) begin
         casc_reads++;
      end
      shr_seen = shr;
      if (ticks == 2000) begin
         fails++;
         conclude();
      end
   end
   // Compare and report
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Every status code in turn, each followed by idle, in one mode
   task automatic all_codes(input logic mode);
      int p;
      int r;
      logic act;
      @(posedge clk);
      iom <= mode;
      @(posedge clk);
      for (int c = 0; c < 8; c++) begin
         p = pulses;
         r = casc_reads;
         u_cpu.run(3'(c), 3);
         #1;
         act = (c != 3) && (c != 7);
         chk(stb, LOWS[c]);
         chk(7'(xen), 7'(act));
         chk(7'(dir), 7'(c == 2 || c == 6));
         chk(7'(shr), 7'(mode ? !act : c == 0));
         chk(7'(pulses - p), 7'(act));
         chk(7'(casc_reads - r), 7'(!mode && c == 0));
         chk(7'(oe), 7'h01);
         @(posedge clk);
         #1;
         chk(stb, 7'h7f);
      end
   endtask
   // Cycle ended just after the early write phase
   task automatic early_only();
      for (int i = 0; i < 2; i++) begin
         u_cpu.run(i ? 3'h2 : 3'h6, 2);
         #1;
         chk(stb, i ? 7'h7d : 7'h6f);
      end
   endtask
   // Address gate float and command gate hold
   task automatic gating();
      @(posedge clk);
      agn <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(7'(oe), 7'h00);
      @(posedge clk);
      iom <= 1'b1;
      gate <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(7'(oe), 7'h01);
      u_cpu.run(3'h5, 3);
      #1;
      chk(stb, 7'h7f);
      chk({5'h00, xen, shr}, 7'h01);
   endtask
   // Verdict and end of run
   task automatic conclude();
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      all_codes(1'b0);
      all_codes(1'b1);
      @(posedge clk);
      iom <= 1'b0;
      early_only();
      gating();
      conclude();
   end
endmodule // bus_cmd_ctrl_tb_top
